// >>> motion_gate_map.svh
// Register offsets, field positions and timing counts of the gating block
`ifndef MOTION_GATE_MAP_SVH
`define MOTION_GATE_MAP_SVH
// ****************************************
// Device register map
// ****************************************
`define MAP_OFS_GCONF      7'h00
`define MAP_OFS_CURCONF    7'h05
`define MAP_OFS_START_DLY  7'h13
`define MAP_OFS_GATE_DLY   7'h14
`define MAP_OFS_STBY_DLY   7'h15
`define MAP_OFS_TRIGGER    7'h4f
`define MAP_GCONF_RESET    32'h00006020
`define MAP_BIT_GATE_EN    17
`define MAP_BIT_STBY_EN    18
`define MAP_BIT_HOLD_SCALE 0
`define MAP_TRIG_GO        3'h7
`define MAP_TRIG_STOP      3'h0
`define MAP_WAKE_DELAY     32'h0fffffff
`define MAP_WAKE_LEAD      32'h00000010
// ****************************************
// Link framing
// ****************************************
`define MAP_FRAME_BITS     6'h28
`define MAP_STAT_BITS      6'h08
`define MAP_SCLK_HALF      8'h04
// ****************************************
// Controller register map (AXI byte addresses)
// ****************************************
`define MAP_A_CTRL         8'h00
`define MAP_A_ADDR         8'h04
`define MAP_A_DATA         8'h08
`define MAP_A_STATUS       8'h0c
`define MAP_A_RDATA        8'h10
`define MAP_A_STBY_VAL     8'h14
`define MAP_A_CUR_VAL      8'h18
`define MAP_A_GDLY_VAL     8'h1c
`define MAP_A_GCONF        8'h20
`define MAP_CTRL_SINGLE    0
`define MAP_CTRL_WAKE      1
`define MAP_CTRL_SETUP     2
`define MAP_CTRL_WRITE     3
`define MAP_STAT_REFUSED   1
`endif

// >>> motion_gate_pkg.sv
// Types for the two ends of the gating link: gate states for the device, link and sequence states for the host
package motion_gate_pkg;
	typedef enum logic [1:0] {
		GATE_RUN   = 2'b00,
		GATE_COUNT = 2'b01,
		GATE_OFF   = 2'b11
	} gate_state_t;
	typedef enum logic [1:0] {
		LNK_IDLE  = 2'b00,
		LNK_SETUP = 2'b01,
		LNK_SHIFT = 2'b11,
		LNK_HOLD  = 2'b10
	} link_state_t;
	typedef enum logic [1:0] {
		SEQ_NONE  = 2'b00,
		SEQ_ONE   = 2'b01,
		SEQ_WAKE  = 2'b11,
		SEQ_SETUP = 2'b10
	} seq_kind_t;
endpackage : motion_gate_pkg

// >>> spi_link_if.sv
// Serial register link between controller and motion device
`timescale 1ns/1ps
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport device (input sclk, input cs_n, input mosi, output miso);
	modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if

// >>> motion_gate_device.sv
// Motion device end: register file, standby timers and clock gating control
// Overview of operation
// - Host triggers gating only at zero velocity
// - Trigger value 0x7 starts gating sequence
// - Trigger loads delay counter, gate at zero
// - Zero delay gates immediately
// - Step input high ends gating
// - Host wake sequence via link writes
// - Standby entry starts delay counter when enabled
// - Host programs automatic gating setup in order
// - Standby entered when standby delay expires
// - Start delay timer from stop to start
// - Gating lifted shortly before start delay expires
// - Sequence begins at target reached, zero velocity
// - Gating enable bit allows gating
// - Standby gating enable bit allows standby gating
`timescale 1ns/1ps
`include "motion_gate_map.svh"
module motion_gate_device #(
	parameter logic [31:0] WAKE_LEAD = `MAP_WAKE_LEAD
) (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       VEL_ZERO_I,
	input  wire logic [1:0] VELOCITY_STATE_FIELD_I,
	input  wire logic       TARGET_REACHED_I,
	input  wire logic       STEP_INPUT_PIN_I,
	output logic            CLK_ENABLE_O,
	output logic            STANDBY_O,
	output logic            RAMP_START_O,
	spi_link_if.device      LINK
);
	// ****************************************
	// Link slave, kept on the ungated clock
	// ****************************************
	logic        sclk_q;
	logic        cs_n_q;
	logic [5:0]  bit_cnt_q;
	logic [39:0] shift_in_q;
	logic [39:0] shift_out_q;
	logic        rise;
	logic        fall;
	logic        wr_stb;
	logic [6:0]  wr_addr;
	logic [31:0] wr_data;
	logic [6:0]  rd_addr;
	logic [31:0] rd_data;
	logic [7:0]  status;
	logic [31:0] gconf_q;
	logic [31:0] curconf_q;
	logic [31:0] gate_dly_q;
	logic [31:0] stby_dly_q;
	logic [31:0] start_dly_q;
	logic [2:0]  trig_q;
	motion_gate_pkg::gate_state_t gate_q;
	logic [31:0] gate_cnt_q;
	logic        stby_run_q;
	logic [31:0] stby_cnt_q;
	logic        start_run_q;
	logic [31:0] start_cnt_q;
	logic        stby_entry;
	logic        lead_wake;
	logic        wake;
	logic        trig_go;
	logic        trig_abort;
	logic        ramp_stop;

	assign rise    = LINK.sclk & ~sclk_q;
	assign fall    = ~LINK.sclk & sclk_q;
	assign wr_addr = shift_in_q[38:32];
	assign wr_data = shift_in_q[31:0];
	// Commit only whole frames; a cut frame leaves all registers alone
	assign wr_stb  = LINK.cs_n & ~cs_n_q & (bit_cnt_q == `MAP_FRAME_BITS) & shift_in_q[39];
	assign rd_addr = {shift_in_q[5:0], LINK.mosi};
	assign status  = {gate_q == motion_gate_pkg::GATE_OFF, STANDBY_O,
		gate_q == motion_gate_pkg::GATE_COUNT, 3'h0, VELOCITY_STATE_FIELD_I};

	always_comb begin
		case (rd_addr)
			`MAP_OFS_GCONF:     rd_data = gconf_q;
			`MAP_OFS_CURCONF:   rd_data = curconf_q;
			`MAP_OFS_START_DLY: rd_data = start_dly_q;
			`MAP_OFS_GATE_DLY:  rd_data = gate_dly_q;
			`MAP_OFS_STBY_DLY:  rd_data = stby_dly_q;
			`MAP_OFS_TRIGGER:   rd_data = {29'h0, trig_q};
			default:            rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= LINK.sclk;
			cs_n_q <= LINK.cs_n;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			bit_cnt_q   <= 6'h0;
			shift_in_q  <= 40'h0;
			shift_out_q <= 40'h0;
		end else if (LINK.cs_n) begin
			bit_cnt_q <= 6'h0;
		end else if (cs_n_q) begin
			shift_out_q <= {status, 32'h0};
		end else if (rise) begin
			shift_in_q <= {shift_in_q[38:0], LINK.mosi};
			bit_cnt_q  <= bit_cnt_q + 6'h1;
			// Address is complete on this edge; data follows the status byte
			if (bit_cnt_q == `MAP_STAT_BITS - 6'h1)
				shift_out_q <= {shift_out_q[39], rd_data, 7'h0};
		end else if (fall) begin
			shift_out_q <= {shift_out_q[38:0], 1'b0};
		end
	end
	assign LINK.miso = shift_out_q[39];

	// ****************************************
	// Register file
	// ****************************************
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			gconf_q     <= `MAP_GCONF_RESET;
			curconf_q   <= 32'h0;
			gate_dly_q  <= 32'h0;
			stby_dly_q  <= 32'h0;
			start_dly_q <= 32'h0;
			trig_q      <= 3'h0;
		end else if (wr_stb) begin
			case (wr_addr)
				`MAP_OFS_GCONF:     gconf_q <= wr_data;
				`MAP_OFS_CURCONF:   curconf_q <= wr_data;
				`MAP_OFS_START_DLY: start_dly_q <= wr_data;
				`MAP_OFS_GATE_DLY:  gate_dly_q <= wr_data;
				`MAP_OFS_STBY_DLY:  stby_dly_q <= wr_data;
				`MAP_OFS_TRIGGER:   trig_q <= wr_data[2:0];
				default:            ;
			endcase
		end
	end

	// ****************************************
	// Standby and start delay timers
	// ****************************************
	assign ramp_stop  = TARGET_REACHED_I & VEL_ZERO_I;
	assign stby_entry = stby_run_q & (stby_cnt_q == 32'h0);
	// Lead time so the core has its clock before the next ramp starts
	assign lead_wake  = start_run_q & (start_cnt_q <= WAKE_LEAD);

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			stby_run_q <= 1'b0;
			stby_cnt_q <= 32'h0;
			STANDBY_O  <= 1'b0;
		end else if (!VEL_ZERO_I) begin
			stby_run_q <= 1'b0;
			STANDBY_O  <= 1'b0;
		end else if (ramp_stop) begin
			stby_run_q <= 1'b1;
			stby_cnt_q <= stby_dly_q;
		end else if (stby_entry) begin
			stby_run_q <= 1'b0;
			STANDBY_O  <= 1'b1;
		end else if (stby_run_q) begin
			stby_cnt_q <= stby_cnt_q - 32'h1;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			start_run_q  <= 1'b0;
			start_cnt_q  <= 32'h0;
			RAMP_START_O <= 1'b0;
		end else begin
			RAMP_START_O <= 1'b0;
			if (ramp_stop) begin
				start_run_q <= 1'b1;
				start_cnt_q <= start_dly_q;
			end else if (start_run_q && start_cnt_q == 32'h0) begin
				start_run_q  <= 1'b0;
				RAMP_START_O <= 1'b1;
			end else if (start_run_q) begin
				start_cnt_q <= start_cnt_q - 32'h1;
			end
		end
	end

	// ****************************************
	// Gating control
	// ****************************************
	assign trig_go    = wr_stb & (wr_addr == `MAP_OFS_TRIGGER) & (wr_data[2:0] == `MAP_TRIG_GO);
	assign trig_abort = wr_stb & (wr_addr == `MAP_OFS_TRIGGER) & (wr_data[2:0] != `MAP_TRIG_GO);
	// Clearing the enable is the link wake path
	assign wake = STEP_INPUT_PIN_I | ~gconf_q[`MAP_BIT_GATE_EN] | lead_wake;

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			gate_q     <= motion_gate_pkg::GATE_RUN;
			gate_cnt_q <= 32'h0;
		end else begin
			case (gate_q)
				motion_gate_pkg::GATE_RUN: begin
					if (gconf_q[`MAP_BIT_GATE_EN] && (trig_go ||
						(stby_entry && gconf_q[`MAP_BIT_STBY_EN]))) begin
						gate_cnt_q <= gate_dly_q;
						gate_q <= (gate_dly_q == 32'h0) ? motion_gate_pkg::GATE_OFF
							: motion_gate_pkg::GATE_COUNT;
					end
				end
				motion_gate_pkg::GATE_COUNT: begin
					if (wake || trig_abort)
						gate_q <= motion_gate_pkg::GATE_RUN;
					else if (gate_cnt_q == 32'h0)
						gate_q <= motion_gate_pkg::GATE_OFF;
					else
						gate_cnt_q <= gate_cnt_q - 32'h1;
				end
				motion_gate_pkg::GATE_OFF: begin
					if (wake)
						gate_q <= motion_gate_pkg::GATE_RUN;
				end
				default: gate_q <= motion_gate_pkg::GATE_RUN;
			endcase
		end
	end
	// Only the motion core is gated; link and registers keep running
	assign CLK_ENABLE_O = (gate_q != motion_gate_pkg::GATE_OFF);
endmodule : motion_gate_device

// >>> motion_gate_host.sv
// Controller end: AXI4-Lite registers, frame sequencer and link master
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "motion_gate_map.svh"
module motion_gate_host #(
	parameter logic [7:0] SCLK_HALF = `MAP_SCLK_HALF
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	spi_link_if.host         LINK
);
	logic        aw_q, w_q, wr_go, busy;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [6:0]  addr_q;
	logic [31:0] data_q, rdata_q, stby_q, cur_q, gdly_q, gconf_q;
	logic [7:0]  stat_q;
	logic        refused_q, wr_flag_q, guard_hit;
	logic [2:0]  idx_q;
	logic [39:0] frame_q, step;
	logic [39:0] rx_q;
	logic [5:0]  bits_q;
	logic [7:0]  div_q;
	logic        tick, frame_done;
	motion_gate_pkg::seq_kind_t  seq_q;
	motion_gate_pkg::link_state_t lnk_q;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign S_AXI_AWREADY_O = ~aw_q & ~S_AXI_BVALID_O;
	assign S_AXI_WREADY_O  = ~w_q & ~S_AXI_BVALID_O;
	assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
	assign wr_go = aw_q & w_q & ~S_AXI_BVALID_O;
	assign busy  = (seq_q != motion_gate_pkg::SEQ_NONE);

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 8'h0; wdata_q <= 32'h0;
			S_AXI_BVALID_O <= 1'b0; S_AXI_BRESP_O <= 2'h0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_q <= 1'b1; awaddr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_q <= 1'b1; wdata_q <= S_AXI_WDATA_I;
			end
			if (wr_go) begin
				aw_q <= 1'b0; w_q <= 1'b0; S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= (awaddr_q > `MAP_A_GCONF || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			S_AXI_RVALID_O <= 1'b0; S_AXI_RDATA_O <= 32'h0; S_AXI_RRESP_O <= 2'h0;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RRESP_O  <= 2'h0;
			case (S_AXI_ARADDR_I)
				`MAP_A_ADDR:     S_AXI_RDATA_O <= {25'h0, addr_q};
				`MAP_A_DATA:     S_AXI_RDATA_O <= data_q;
				`MAP_A_STATUS:   S_AXI_RDATA_O <= {16'h0, stat_q, 6'h0, refused_q, busy};
				`MAP_A_RDATA:    S_AXI_RDATA_O <= rdata_q;
				`MAP_A_STBY_VAL: S_AXI_RDATA_O <= stby_q;
				`MAP_A_CUR_VAL:  S_AXI_RDATA_O <= cur_q;
				`MAP_A_GDLY_VAL: S_AXI_RDATA_O <= gdly_q;
				`MAP_A_GCONF:    S_AXI_RDATA_O <= gconf_q;
				`MAP_A_CTRL:     S_AXI_RDATA_O <= {28'h0, wr_flag_q, 3'h0};
				default: begin
					S_AXI_RDATA_O <= 32'h0;
					S_AXI_RRESP_O <= 2'h2;
				end
			endcase
		end else if (S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

	// Byte lanes ignored: every word written whole
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			addr_q <= 7'h0; data_q <= 32'h0; stby_q <= 32'h0; cur_q <= 32'h0;
			gdly_q <= 32'h0; wr_flag_q <= 1'b0;
		end else if (wr_go) begin
			case (awaddr_q)
				`MAP_A_ADDR:     addr_q <= wdata_q[6:0];
				`MAP_A_DATA:     data_q <= wdata_q;
				`MAP_A_STBY_VAL: stby_q <= wdata_q;
				`MAP_A_CUR_VAL:  cur_q <= wdata_q;
				`MAP_A_GDLY_VAL: gdly_q <= wdata_q;
				`MAP_A_CTRL:     wr_flag_q <= wdata_q[`MAP_CTRL_WRITE];
				default:         ;
			endcase
		end
	end

	// ****************************************
	// Frame sequencer
	// ****************************************
	function automatic logic [39:0] step_of(input motion_gate_pkg::seq_kind_t k,
		input logic [2:0] i);
		logic [31:0] g;
		g = gconf_q;
		step_of = 40'h0;
		case (k)
			motion_gate_pkg::SEQ_WAKE: begin
				g[`MAP_BIT_GATE_EN] = 1'b0;
				case (i)
					3'h0:    step_of = {1'b1, `MAP_OFS_GATE_DLY, `MAP_WAKE_DELAY};
					3'h1:    step_of = {1'b1, `MAP_OFS_TRIGGER, 29'h0, `MAP_TRIG_STOP};
					3'h2:    step_of = {1'b1, `MAP_OFS_TRIGGER, 29'h0, `MAP_TRIG_GO};
					default: step_of = {1'b1, `MAP_OFS_GCONF, g};
				endcase
			end
			motion_gate_pkg::SEQ_SETUP: begin
				g[`MAP_BIT_GATE_EN] = 1'b1;
				case (i)
					3'h0:    step_of = {1'b1, `MAP_OFS_STBY_DLY, stby_q};
					3'h1:    step_of = {1'b1, `MAP_OFS_CURCONF, cur_q | 32'h1 << `MAP_BIT_HOLD_SCALE};
					3'h2:    step_of = {1'b1, `MAP_OFS_GCONF, g};
					3'h3:    step_of = {1'b1, `MAP_OFS_GATE_DLY, gdly_q};
					default: begin
						g[`MAP_BIT_STBY_EN] = 1'b1;
						step_of = {1'b1, `MAP_OFS_GCONF, g};
					end
				endcase
			end
			default: step_of = {wr_flag_q, addr_q, data_q};
		endcase
	endfunction
	assign step = step_of(seq_q, idx_q);

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seq_q <= motion_gate_pkg::SEQ_NONE;
			idx_q <= 3'h0;
		end else if (!busy) begin
			idx_q <= 3'h0;
			// Commands arriving while busy are dropped
			if (wr_go && awaddr_q == `MAP_A_CTRL) begin
				if (wdata_q[`MAP_CTRL_WAKE])        seq_q <= motion_gate_pkg::SEQ_WAKE;
				else if (wdata_q[`MAP_CTRL_SETUP])  seq_q <= motion_gate_pkg::SEQ_SETUP;
				else if (wdata_q[`MAP_CTRL_SINGLE]) seq_q <= motion_gate_pkg::SEQ_ONE;
			end
		end else if (frame_done) begin
			idx_q <= idx_q + 3'h1;
			if (seq_q == motion_gate_pkg::SEQ_ONE ||
				(seq_q == motion_gate_pkg::SEQ_WAKE && idx_q == 3'h3) ||
				(seq_q == motion_gate_pkg::SEQ_SETUP && idx_q == 3'h4))
				seq_q <= motion_gate_pkg::SEQ_NONE;
		end
	end

	// ****************************************
	// Link master
	// ****************************************
	assign tick = (div_q == SCLK_HALF - 8'h1);
	assign frame_done = (lnk_q == motion_gate_pkg::LNK_HOLD) & tick;
	// Trigger write turned into a stop when the status shows motion
	assign guard_hit = frame_q[39] & (frame_q[38:32] == `MAP_OFS_TRIGGER) &
		(frame_q[2:0] == `MAP_TRIG_GO) & (rx_q[1:0] != 2'h0);

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_q <= 8'h0;
		end else if (lnk_q == motion_gate_pkg::LNK_IDLE || tick) begin
			div_q <= 8'h0;
		end else begin
			div_q <= div_q + 8'h1;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lnk_q <= motion_gate_pkg::LNK_IDLE; frame_q <= 40'h0; rx_q <= 40'h0;
			bits_q <= 6'h0; LINK.sclk <= 1'b0; LINK.cs_n <= 1'b1; LINK.mosi <= 1'b0;
			rdata_q <= 32'h0; stat_q <= 8'h0; refused_q <= 1'b0; gconf_q <= `MAP_GCONF_RESET;
		end else begin
			if (wr_go && awaddr_q == `MAP_A_STATUS && wdata_q[`MAP_STAT_REFUSED])
				refused_q <= 1'b0;
			if (wr_go && awaddr_q == `MAP_A_GCONF)
				gconf_q <= wdata_q;
			case (lnk_q)
				motion_gate_pkg::LNK_IDLE: begin
					if (busy && !frame_done) begin
						frame_q <= step; LINK.cs_n <= 1'b0; LINK.mosi <= step[39];
						bits_q <= 6'h0; lnk_q <= motion_gate_pkg::LNK_SETUP;
					end
				end
				motion_gate_pkg::LNK_SETUP: begin
					if (tick) lnk_q <= motion_gate_pkg::LNK_SHIFT;
				end
				motion_gate_pkg::LNK_SHIFT: begin
					if (tick && !LINK.sclk) begin
						LINK.sclk <= 1'b1;
						rx_q <= {rx_q[38:0], LINK.miso};
						bits_q <= bits_q + 6'h1;
					end else if (tick) begin
						LINK.sclk <= 1'b0;
						if (bits_q == `MAP_FRAME_BITS) begin
							lnk_q <= motion_gate_pkg::LNK_HOLD;
						end else if (bits_q == `MAP_STAT_BITS && guard_hit) begin
							frame_q[2:0] <= `MAP_TRIG_STOP;
							refused_q <= 1'b1;
							LINK.mosi <= frame_q[31];
						end else begin
							LINK.mosi <= frame_q[6'd39 - bits_q];
						end
					end
				end
				motion_gate_pkg::LNK_HOLD: begin
					if (tick) begin
						LINK.cs_n <= 1'b1; lnk_q <= motion_gate_pkg::LNK_IDLE;
						stat_q <= rx_q[39:32]; rdata_q <= rx_q[31:0];
						if (frame_q[39] && frame_q[38:32] == `MAP_OFS_GCONF)
							gconf_q <= frame_q[31:0];
					end
				end
				default: lnk_q <= motion_gate_pkg::LNK_IDLE;
			endcase
		end
	end
endmodule : motion_gate_host

// >>> motion_gate_checker.sv
// Assertions on the gating link and the device outputs
`timescale 1ns/1ps
module motion_gate_checker (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic VEL_ZERO_I,
	input wire logic STEP_INPUT_PIN_I,
	input wire logic CLK_ENABLE_O,
	input wire logic STANDBY_O,
	input wire logic RAMP_START_O
);
	logic       sclk_q;
	logic [5:0] rises_q;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// ****
	// Rises seen in the current frame
	// ****
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rises_q <= 6'h00;
		end else if (cs_n) begin
			rises_q <= 6'h00;
		end else if (sclk && !sclk_q) begin
			rises_q <= rises_q + 6'h01;
		end
	end
	// ****
	// Properties
	// ****
	a_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("link clock runs outside a frame");
	a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while clock high");
	a_miso_hold: assert property (sclk && $past(sclk) |-> $stable(miso))
		else $error("miso moved while clock high");
	a_frame_count: assert property ($rose(cs_n) |-> rises_q == 6'h28)
		else $error("frame without forty clock rises");
	a_step_wake: assert property (STEP_INPUT_PIN_I && !CLK_ENABLE_O |-> ##[1:2] CLK_ENABLE_O)
		else $error("step pin did not restore the clock");
	a_ramp_pulse: assert property (RAMP_START_O |=> !RAMP_START_O)
		else $error("ramp start longer than one cycle");
	a_standby_drop: assert property (!VEL_ZERO_I |=> !STANDBY_O)
		else $error("standby held while moving");
	a_ramp_awake: assert property (RAMP_START_O |-> CLK_ENABLE_O && $past(CLK_ENABLE_O, 8))
		else $error("clock not restored ahead of ramp start");
	// Main paths reached
	cover property ($rose(cs_n));
	cover property ($fell(CLK_ENABLE_O));
	cover property (RAMP_START_O);
endmodule : motion_gate_checker

// >>> motion_ctrl_clock_gating_test.sv
// Self-checking bench joining controller and device over the link
`timescale 1ns/1ps
`include "motion_gate_map.svh"
module motion_ctrl_clock_gating_test;
	typedef struct packed {logic [1:0] r; logic [31:0] d; logic [31:0] m;} note_t;
	logic        clk, rst_n, vz, tr, stp, ce, sb, rs, ta, tw, tb;
	logic        awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
	logic [1:0]  vs, br, rr;
	logic [7:0]  awa, ara, lf;
	logic [31:0] wd, rd, d, x;
	int          n_fail, total_checks, c, c2, s, ts, tg, tu, tp;
	note_t       q[$];
	logic [1:0]  bq[$];
	spi_link_if u_spi_link_if ();
	motion_gate_device u_motion_gate_device (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.VEL_ZERO_I(vz), .VELOCITY_STATE_FIELD_I(vs), .TARGET_REACHED_I(tr),
		.STEP_INPUT_PIN_I(stp), .CLK_ENABLE_O(ce), .STANDBY_O(sb), .RAMP_START_O(rs),
		.LINK(u_spi_link_if.device));
	motion_gate_host u_motion_gate_host (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
		.LINK(u_spi_link_if.host));
	motion_gate_checker u_motion_gate_checker (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.sclk(u_spi_link_if.sclk), .cs_n(u_spi_link_if.cs_n), .mosi(u_spi_link_if.mosi),
		.miso(u_spi_link_if.miso), .VEL_ZERO_I(vz), .STEP_INPUT_PIN_I(stp),
		.CLK_ENABLE_O(ce), .STANDBY_O(sb), .RAMP_START_O(rs));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ****
	// Helpers
	// ****
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic lost();
		n_fail++;
		$display("[ERR] %0t wait ran out", $time);
		report_and_stop();
	endtask : lost
	task automatic cmp_val(input logic [1:0] g, input logic [1:0] w, input string m);
		total_checks++;
		if (g !== w) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : cmp_val
	task automatic cmp_rd(input note_t e, input logic [1:0] r, input logic [31:0] v);
		total_checks++;
		if (r !== e.r || (v & e.m) !== (e.d & e.m)) begin
			n_fail++;
			$display("[ERR] %0t read %h %h want %h %h", $time, r, v, e.r, e.d);
		end
	endtask : cmp_rd
	// Both channels offered together, each dropped once taken
	task automatic wr32(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge clk);
		bq.push_back(e);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (c = 0; c < 99 && (c == 0 || bry); c++) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr;
			tb = bry && bv;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) bry <= 1'b0;
		end
		if (c >= 99) lost();
	endtask : wr32
	task automatic rd32(input logic [7:0] a, input note_t e, output logic [31:0] v);
		@(posedge clk);
		q.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (c = 0; c < 99 && (c == 0 || rry); c++) begin
			@(negedge clk);
			ta = arv && arr;
			tb = rv && rry;
			v = rd;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (tb) rry <= 1'b0;
		end
		if (c >= 99) lost();
	endtask : rd32
	task automatic busy();
		logic [31:0] st;
		st = 32'h1;
		for (int k = 0; k < 900 && st[0]; k++) rd32(`MAP_A_STATUS, '0, st);
		if (st[0]) lost();
	endtask : busy
	task automatic frame(input logic w, input logic [6:0] a, input logic [31:0] v);
		wr32(`MAP_A_ADDR, {25'h0, a}, 2'h0);
		wr32(`MAP_A_DATA, v, 2'h0);
		wr32(`MAP_A_CTRL, {28'h0, w, 3'h1}, 2'h0);
		busy();
	endtask : frame
	// Answers are checked as they appear, oldest note first
	always @(negedge clk) begin
		if (rv && rry) cmp_rd(q.pop_front(), rr, rd);
		if (bv && bry) cmp_val(br, bq.pop_front(), "write response");
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{rst_n, tr, stp, awv, wv, bry, arv, rry, vs} = '0;
		{awa, ara, wd} = '0;
		vz = 1'b1;
		n_fail = 0;
		total_checks = 0;
		lf = 8'h12;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd32(`MAP_A_GCONF, {2'h0, `MAP_GCONF_RESET, 32'hffffffff}, x);
		rd32(8'h40, {2'h2, 32'h0, 32'hffffffff}, x);
		wr32(8'h44, 32'h1, 2'h2);
		lf = nxt(lf);
		vs <= lf[1:0];
		frame(1'b0, `MAP_OFS_GCONF, 32'h0);
		rd32(`MAP_A_RDATA, {2'h0, `MAP_GCONF_RESET, 32'hffffffff}, x);
		rd32(`MAP_A_STATUS, {2'h0, 22'h0, lf[1:0], 8'h0, 32'h300}, x);
		vs <= 2'h0;
		$display("reset and status test done");
		frame(1'b1, `MAP_OFS_TRIGGER, 32'h7);
		cmp_val({1'b0, ce}, 2'h1, "gated while disabled");
		frame(1'b1, `MAP_OFS_GCONF, 32'h00026020);
		frame(1'b1, `MAP_OFS_TRIGGER, 32'h7);
		cmp_val({1'b0, ce}, 2'h0, "zero delay did not gate");
		stp <= 1'b1;
		repeat (3) @(posedge clk);
		cmp_val({1'b0, ce}, 2'h1, "step pin did not wake");
		stp <= 1'b0;
		$display("immediate gating test done");
		vs <= 2'h2;
		frame(1'b1, `MAP_OFS_TRIGGER, 32'h7);
		cmp_val({1'b0, ce}, 2'h1, "gated while moving");
		vs <= 2'h0;
		rd32(`MAP_A_STATUS, {2'h0, 32'h2, 32'h3}, x);
		wr32(`MAP_A_STATUS, 32'h2, 2'h0);
		rd32(`MAP_A_STATUS, {2'h0, 32'h0, 32'h3}, x);
		$display("refused trigger test done");
		lf = nxt(lf);
		d = {24'h0, lf} + 32'd100;
		frame(1'b1, `MAP_OFS_GATE_DLY, d);
		fork
			frame(1'b1, `MAP_OFS_TRIGGER, 32'h7);
			begin
				for (c2 = 0; c2 < 99 && u_spi_link_if.cs_n; c2++) @(negedge clk);
				if (c2 >= 99) lost();
				for (c2 = 0; c2 < 999 && !u_spi_link_if.cs_n; c2++) @(negedge clk);
				if (c2 >= 999) lost();
				for (c2 = 0; c2 < 600 && ce; c2++) @(negedge clk);
			end
		join
		cmp_val({1'b0, c2 >= d + 1 && c2 <= d + 3}, 2'h1, "delay count");
		wr32(`MAP_A_CTRL, 32'h2, 2'h0);
		busy();
		cmp_val({1'b0, ce}, 2'h1, "link wake failed");
		rd32(`MAP_A_GCONF, {2'h0, `MAP_GCONF_RESET, 32'hffffffff}, x);
		$display("delayed gating test done");
		lf = nxt(lf);
		s = 40 + lf[4:0];
		wr32(`MAP_A_STBY_VAL, 32'(s), 2'h0);
		wr32(`MAP_A_CUR_VAL, 32'h0, 2'h0);
		wr32(`MAP_A_GDLY_VAL, 32'd30, 2'h0);
		wr32(`MAP_A_CTRL, 32'h4, 2'h0);
		busy();
		frame(1'b1, `MAP_OFS_START_DLY, 32'd600);
		tr <= 1'b1;
		@(posedge clk);
		tr <= 1'b0;
		{ts, tg, tu, tp} = '0;
		for (c2 = 1; c2 < 800 && tp == 0; c2++) begin
			@(negedge clk);
			if (sb && ts == 0) ts = c2;
			if (!ce && tg == 0) tg = c2;
			if (ce && tg != 0 && tu == 0) tu = c2;
			if (rs) tp = c2;
		end
		cmp_val({1'b0, ts >= s && ts <= s + 3}, 2'h1, "standby time");
		cmp_val({1'b0, ts > 0 && tg >= ts + 30 && tg <= ts + 33}, 2'h1, "gate time");
		cmp_val({1'b0, tu != 0 && tu < tp}, 2'h1, "late wake");
		cmp_val({1'b0, tp >= 600 && tp <= 603}, 2'h1, "start time");
		@(posedge clk);
		vz <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_val({1'b0, sb}, 2'h0, "standby kept while moving");
		$display("automatic gating test done");
		report_and_stop();
	end
endmodule : motion_ctrl_clock_gating_test
